/* hdl/assf_pkg.sv */
// Shared constants and types for the audio serial slot formatter.
package assf_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int LINK_PERIOD_NS = 320;
	localparam int BCLK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

	// ------------------------------------------------------------
	// Modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ASSF_FMT_LJ,
		ASSF_FMT_I2S,
		ASSF_FMT_DSP
	} assf_fmt_type;

	localparam logic [1:0] WLEN_16 = 2'h0;
	localparam logic [1:0] WLEN_20 = 2'h1;
	localparam logic [1:0] WLEN_24 = 2'h2;
	localparam logic [1:0] WLEN_32 = 2'h3;

	function automatic logic [5:0] assf_word_bits(input logic [1:0] code);
		case (code)
			WLEN_16: assf_word_bits = 6'h10;
			WLEN_20: assf_word_bits = 6'h14;
			WLEN_24: assf_word_bits = 6'h18;
			default: assf_word_bits = 6'h20;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Controller register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OFFS = 8'h04;
	localparam logic [7:0] REG_LEFT = 8'h08;
	localparam logic [7:0] REG_RIGHT = 8'h0c;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam int CTRL_EN = 0;
	localparam int CTRL_FMT = 1;
	localparam int CTRL_WLEN = 3;
	localparam int CTRL_TSLOT = 5;
	localparam int CTRL_SWAP = 6;
	localparam int CTRL_INV = 7;
	localparam int OFFS_OFF1 = 0;
	localparam int OFFS_OFF2 = 8;
	localparam int OFFS_NBCLK = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] OFFS_RESET = 32'h0040_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* hdl/assf_link_if.sv */
// Audio serial link between the formatter and its receiving controller.
`timescale 1ns/1ps
interface assf_link_if;
	logic bclk;
	logic wclk;
	logic dout;
	logic dout_oe;
	modport dev (
		input bclk,
		input wclk,
		output dout,
		output dout_oe
	);
	modport host (
		output bclk,
		output wclk,
		input dout,
		input dout_oe
	);
endinterface

/* hdl/assf_device.sv */
// Device end: shifts channel words onto the serial data line.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module assf_device
	import assf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	assf_link_if.dev link,
	input wire assf_fmt_type fmt,
	input wire logic [1:0] wlen,
	input wire logic tslot,
	input wire logic swap,
	input wire logic bclk_inv,
	input wire logic hiz_en,
	input wire logic early_hiz,
	input wire logic [7:0] first_slot_offset,
	input wire logic [7:0] second_slot_offset,
	input wire logic [31:0] left_word,
	input wire logic [31:0] right_word,
	output logic word_taken
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_SHIFT
	} assf_dev_state_type;

	// ------------------------------------------------------------
	// Link synchronisers
	// ------------------------------------------------------------
	logic bclk_s1;
	logic bclk_s2;
	logic bclk_s3;
	logic wclk_s1;
	logic wclk_s2;
	logic wclk_seen;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bclk_s1 <= 1'b0;
			bclk_s2 <= 1'b0;
			bclk_s3 <= 1'b0;
			wclk_s1 <= 1'b0;
			wclk_s2 <= 1'b0;
		end else begin
			bclk_s1 <= link.bclk;
			bclk_s2 <= bclk_s1;
			bclk_s3 <= bclk_s2;
			wclk_s1 <= link.wclk;
			wclk_s2 <= wclk_s1;
		end
	end

	// ------------------------------------------------------------
	// Edge and event decode
	// ------------------------------------------------------------
	logic is_i2s;
	logic is_dsp;
	logic launch_on_rise;
	logic b_rise;
	logic b_fall;
	logic launch;
	logic sample;
	logic w_rise;
	logic w_fall;
	logic first_ev;
	logic second_ev;
	logic [5:0] nbits;
	logic [8:0] first_delay;
	logic [8:0] gap_delay;

	assign is_i2s = (fmt == ASSF_FMT_I2S);
	assign is_dsp = (fmt == ASSF_FMT_DSP);
	// Data is launched on the edge opposite the one the receiver samples.
	assign launch_on_rise = is_dsp ^ bclk_inv;
	assign b_rise = bclk_s2 & ~bclk_s3;
	assign b_fall = ~bclk_s2 & bclk_s3;
	assign launch = launch_on_rise ? b_rise : b_fall;
	assign sample = launch_on_rise ? b_fall : b_rise;
	// Word clock is judged against its level at the previous launch edge.
	assign w_rise = wclk_s2 & ~wclk_seen;
	assign w_fall = ~wclk_s2 & wclk_seen;
	assign first_ev = is_i2s ? w_fall : w_rise;
	assign second_ev = is_i2s ? w_rise : w_fall;
	assign nbits = assf_word_bits(wlen);
	// I2S places the MSB one bit clock later than the other formats.
	assign first_delay = {1'b0, first_slot_offset} + {8'h00, is_i2s};
	always_comb begin
		if (!tslot) begin
			gap_delay = 9'h000;
		end else if (is_dsp) begin
			if (second_slot_offset == 8'h00) begin
				gap_delay = 9'h000;
			end else begin
				gap_delay = {1'b0, second_slot_offset} - 9'h001;
			end
		end else begin
			gap_delay = {1'b0, second_slot_offset};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wclk_seen <= 1'b0;
		end else if (launch) begin
			wclk_seen <= wclk_s2;
		end
	end

	// ------------------------------------------------------------
	// Slot sequencer
	// ------------------------------------------------------------
	assf_dev_state_type state;
	assf_dev_state_type next_state;
	logic [8:0] cnt;
	logic [8:0] next_cnt;
	logic second;
	logic next_second;
	logic go;
	logic start;
	logic start_second;
	logic [8:0] start_delay;
	logic [5:0] bits;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_second = second;
		go = 1'b0;
		start = 1'b0;
		start_second = 1'b0;
		start_delay = 9'h000;
		if (launch) begin
			if (first_ev) begin
				start = 1'b1;
				start_delay = first_delay;
			end else if (second_ev && !tslot && !is_dsp) begin
				start = 1'b1;
				start_second = 1'b1;
				start_delay = first_delay;
			end else begin
				case (state)
					ST_WAIT: begin
						next_cnt = cnt - 9'h001;
						if (cnt == 9'h001) begin
							go = 1'b1;
							next_state = ST_SHIFT;
						end
					end
					ST_SHIFT: begin
						if (bits == 6'h00) begin
							next_state = ST_IDLE;
							if (!second && (tslot || is_dsp)) begin
								start = 1'b1;
								start_second = 1'b1;
								start_delay = gap_delay;
							end
						end
					end
					default: begin
					end
				endcase
			end
			if (start) begin
				next_second = start_second;
				if (start_delay == 9'h000) begin
					go = 1'b1;
					next_state = ST_SHIFT;
				end else begin
					next_state = ST_WAIT;
					next_cnt = start_delay;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			cnt <= 9'h000;
			second <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			second <= next_second;
		end
	end

	// ------------------------------------------------------------
	// Sample capture
	// ------------------------------------------------------------
	logic [31:0] left_q;
	logic [31:0] right_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			left_q <= 32'h0000_0000;
			right_q <= 32'h0000_0000;
			word_taken <= 1'b0;
		end else begin
			word_taken <= launch & first_ev;
			if (launch && first_ev) begin
				left_q <= left_word;
				right_q <= right_word;
			end
		end
	end

	// ------------------------------------------------------------
	// Shifter and output drive
	// ------------------------------------------------------------
	logic [31:0] shreg;
	logic [31:0] word_src;
	logic [31:0] aligned;
	logic lsb_out;
	logic dout_q;
	logic oe_q;

	// A restart on the first event must use the fresh port words.
	always_comb begin
		if (launch && first_ev) begin
			word_src = swap ? right_word : left_word;
		end else if (next_second ^ swap) begin
			word_src = right_q;
		end else begin
			word_src = left_q;
		end
	end
	assign aligned = word_src << (6'h20 - nbits);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bits <= 6'h00;
			shreg <= 32'h0000_0000;
			lsb_out <= 1'b0;
			dout_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (launch) begin
			if (go) begin
				shreg <= aligned << 1;
				dout_q <= aligned[31];
				bits <= nbits - 6'h01;
				oe_q <= 1'b1;
				lsb_out <= 1'b0;
			end else if (next_state == ST_SHIFT) begin
				shreg <= shreg << 1;
				dout_q <= shreg[31];
				bits <= bits - 6'h01;
				oe_q <= 1'b1;
				lsb_out <= (bits == 6'h01);
			end else begin
				dout_q <= 1'b0;
				oe_q <= ~hiz_en;
				lsb_out <= 1'b0;
			end
		end else if (sample && lsb_out && early_hiz && hiz_en) begin
			// Releasing mid-LSB gives the next talker half a bit of margin.
			oe_q <= 1'b0;
			lsb_out <= 1'b0;
		end
	end

	assign link.dout = dout_q;
	assign link.dout_oe = oe_q;

endmodule // assf_device

/* hdl/assf_host.sv */
// Controller end: makes the link clocks and collects channel words.
`timescale 1ns/1ps
module assf_host
	import assf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	assf_link_if.host link,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	logic [31:0] ctrl;
	logic [31:0] offs;
	logic [31:0] left_rx;
	logic [31:0] right_rx;
	logic [15:0] frames;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic aw_ok;
	logic w_ok;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	logic do_wr;
	logic next_aw_ok;
	logic next_w_ok;
	logic next_rvalid;

	assign do_wr = aw_ok & w_ok & ~s_axi_bvalid;
	assign next_aw_ok = (aw_ok | (s_axi_awvalid & s_axi_awready)) & ~do_wr;
	assign next_w_ok = (w_ok | (s_axi_wvalid & s_axi_wready)) & ~do_wr;
	assign next_rvalid = (s_axi_rvalid & ~s_axi_rready)
		| (s_axi_arvalid & s_axi_arready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			wa <= 8'h00;
			wd <= 32'h0000_0000;
			ws <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			ctrl <= CTRL_RESET;
			offs <= OFFS_RESET;
		end else begin
			aw_ok <= next_aw_ok;
			w_ok <= next_w_ok;
			s_axi_awready <= ~next_aw_ok;
			s_axi_wready <= ~next_w_ok;
			if (s_axi_awvalid && s_axi_awready) begin
				wa <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd <= s_axi_wdata;
				ws <= s_axi_wstrb;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= RESP_OKAY;
				for (int i = 0; i < 4; i++) begin
					if (ws[i] && wa == REG_CTRL) begin
						ctrl[8*i +: 8] <= wd[8*i +: 8];
					end
					if (ws[i] && wa == REG_OFFS) begin
						offs[8*i +: 8] <= wd[8*i +: 8];
					end
				end
				if (wa != REG_CTRL && wa != REG_OFFS) begin
					s_axi_bresp <= RESP_SLVERR;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_rvalid <= next_rvalid;
			s_axi_arready <= ~next_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rresp <= RESP_OKAY;
				case (s_axi_araddr)
					REG_CTRL: s_axi_rdata <= ctrl;
					REG_OFFS: s_axi_rdata <= offs;
					REG_LEFT: s_axi_rdata <= left_rx;
					REG_RIGHT: s_axi_rdata <= right_rx;
					REG_STAT: s_axi_rdata <= {16'h0000, frames};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Clock generation
	// ------------------------------------------------------------
	logic en;
	// The divider starts one cycle after enable, so an inverted idle level
	// applied at enable is still followed by a full half period.
	logic en_q;
	logic is_i2s;
	logic is_dsp;
	logic [7:0] nbclk;
	logic [7:0] half;
	logic [3:0] hcnt;
	logic ph;
	logic tog;
	logic [7:0] bc;
	logic [7:0] nbc;

	assign en = ctrl[CTRL_EN];
	assign is_i2s = ctrl[CTRL_FMT +: 2] == 2'(ASSF_FMT_I2S);
	assign is_dsp = ctrl[CTRL_FMT +: 2] == 2'(ASSF_FMT_DSP);
	// Frame length must exceed two words and leave room after offsets.
	assign nbclk = offs[OFFS_NBCLK +: 8];
	assign half = {1'b0, nbclk[7:1]};
	assign tog = en_q && (hcnt == 4'(BCLK_HALF_CYCLES - 1));
	assign nbc = (bc == nbclk - 8'h01) ? 8'h00 : bc + 8'h01;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hcnt <= 4'h0;
			en_q <= 1'b0;
			ph <= 1'b0;
			bc <= 8'h00;
			link.bclk <= 1'b0;
			link.wclk <= 1'b0;
		end else begin
			en_q <= en;
			hcnt <= tog || !en_q ? 4'h0 : hcnt + 4'h1;
			if (tog) begin
				ph <= ~ph;
			end
			link.bclk <= (tog ? ~ph : ph) ^ ctrl[CTRL_INV];
			if (tog && ph) begin
				bc <= nbc;
				if (is_dsp) begin
					link.wclk <= (nbc == 8'h00);
				end else if (is_i2s) begin
					link.wclk <= (nbc >= half);
				end else begin
					link.wclk <= (nbc < half);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	logic d_s1;
	logic d_s2;
	logic cap;
	logic [9:0] idx;
	logic [9:0] wbits;
	logic [9:0] p1;
	logic [9:0] p2;
	logic [9:0] gap;
	logic in1;
	logic in2;
	logic [31:0] sh1;
	logic [31:0] sh2;
	logic [31:0] next_sh1;
	logic [31:0] next_sh2;

	// Data is taken a half bit after the receiver's valid edge, which
	// absorbs the synchroniser delay on both ends.
	assign cap = is_dsp ? (tog && !ph) : (tog && ph);
	assign idx = (is_dsp && bc == 8'h00) ? {2'h0, nbclk} - 10'h001
		: {2'h0, bc} - {9'h000, is_dsp};
	assign wbits = {4'h0, assf_word_bits(ctrl[CTRL_WLEN +: 2])};
	assign p1 = {2'h0, offs[OFFS_OFF1 +: 8]} + {9'h000, is_i2s};
	assign gap = (is_dsp && offs[OFFS_OFF2 +: 8] != 8'h00)
		? {2'h0, offs[OFFS_OFF2 +: 8]} - 10'h001
		: {2'h0, offs[OFFS_OFF2 +: 8]};
	always_comb begin
		if (ctrl[CTRL_TSLOT]) begin
			p2 = p1 + wbits + gap;
		end else if (is_dsp) begin
			p2 = p1 + wbits;
		end else begin
			p2 = {2'h0, half} + p1;
		end
	end
	assign in1 = (idx >= p1) && (idx < p1 + wbits);
	assign in2 = (idx >= p2) && (idx < p2 + wbits);
	assign next_sh1 = in1 ? {sh1[30:0], d_s2} : sh1;
	assign next_sh2 = in2 ? {sh2[30:0], d_s2} : sh2;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			d_s1 <= 1'b0;
			d_s2 <= 1'b0;
			sh1 <= 32'h0000_0000;
			sh2 <= 32'h0000_0000;
			left_rx <= 32'h0000_0000;
			right_rx <= 32'h0000_0000;
			frames <= 16'h0000;
		end else begin
			d_s1 <= link.dout;
			d_s2 <= d_s1;
			if (cap) begin
				sh1 <= next_sh1;
				sh2 <= next_sh2;
				if (idx == {2'h0, nbclk} - 10'h001) begin
					left_rx <= ctrl[CTRL_SWAP] ? next_sh2 : next_sh1;
					right_rx <= ctrl[CTRL_SWAP] ? next_sh1 : next_sh2;
					frames <= frames + 16'h0001;
					// Each frame starts from a clear word, so short words
					// read back without bits of the frame before.
					sh1 <= 32'h0000_0000;
					sh2 <= 32'h0000_0000;
				end
			end
		end
	end

endmodule // assf_host

/* bench/assf_link_sva.sv */
// Concurrent checks on the audio serial link between the two ends.
`timescale 1ns/1ps
module assf_link_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic bclk,
	input wire logic wclk,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic hiz_en
);
	// ------------------------------------------------------------
	// Link timing
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_reset_idle: assert property (
		$rose(aresetn) |-> !bclk && !wclk && !dout_oe)
		else $error("link outputs not idle after reset");

	chk_bclk_half: assert property (
		$changed(bclk) |=> $stable(bclk) [*3])
		else $error("bit clock half period shorter than four cycles");

	chk_wclk_align: assert property (
		$changed(wclk) |-> $changed(bclk))
		else $error("word clock moved without a bit clock edge");

	// Data may only move a fixed three cycles after a bit clock edge.
	chk_bit_launch: assert property (
		$changed(dout) |-> $past(bclk, 3) != $past(bclk, 4))
		else $error("serial data changed away from a launch edge");

	chk_data_hold: assert property (
		$changed(dout) |=> $stable(dout) [*7])
		else $error("serial data bit held less than one bit period");

	chk_oe_release: assert property (
		$fell(dout_oe) |-> $past(bclk, 3) != $past(bclk, 4))
		else $error("output released away from a bit clock edge");

	// The shortest word is sixteen bits, so a burst is never this short.
	chk_oe_min_run: assert property (
		$rose(dout_oe) |-> dout_oe [*8])
		else $error("output driven for less than eight cycles");

	chk_fell_hiz: assert property (
		$fell(dout_oe) |-> hiz_en)
		else $error("output floated while floating is disabled");
endmodule // assf_link_sva

/* bench/tb.sv */
// Testbench joining both ends of the audio serial link.
`timescale 1ns/1ps
module tb
	import assf_pkg::*;
;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, word_taken;
	logic [7:0] awaddr, araddr, off1, off2;
	logic [31:0] wdata, rdata, left_word, right_word;
	logic [1:0] bresp, rresp, wlen;
	logic tslot, swap, bclk_inv, hiz_en, early_hiz;
	assf_fmt_type fmt;
	int num_errors, tests_run, cycles;

	assf_link_if i_assf_link_if ();
	assf_device i_assf_device (.aclk(aclk), .aresetn(aresetn),
		.link(i_assf_link_if), .fmt(fmt), .wlen(wlen), .tslot(tslot),
		.swap(swap), .bclk_inv(bclk_inv), .hiz_en(hiz_en),
		.early_hiz(early_hiz), .first_slot_offset(off1),
		.second_slot_offset(off2), .left_word(left_word),
		.right_word(right_word), .word_taken(word_taken));
	assf_host i_assf_host (.aclk(aclk), .aresetn(aresetn),
		.link(i_assf_link_if), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	assf_link_sva i_assf_link_sva (.aclk(aclk), .aresetn(aresetn),
		.bclk(i_assf_link_if.bclk), .wclk(i_assf_link_if.wclk),
		.dout(i_assf_link_if.dout), .dout_oe(i_assf_link_if.dout_oe),
		.hiz_en(hiz_en));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic complete_run();
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Pin edges are judged one step after the system clock edge that
	// moved them, so the design's updates of that edge have landed.
	task automatic wait_edge(input logic wc, input logic lvl);
		logic prev, cur;
		prev = wc ? i_assf_link_if.wclk : i_assf_link_if.bclk;
		forever begin
			@(posedge aclk);
			#1;
			cur = wc ? i_assf_link_if.wclk : i_assf_link_if.bclk;
			if (cur === lvl && prev !== lvl) break;
			prev = cur;
		end
	endtask

	// Flags fl are {early_hiz, hiz_en, bclk_inv, swap, tslot}.
	task automatic run_case(input assf_fmt_type f, input logic [1:0] wl,
		input logic [4:0] fl, input logic [7:0] o1, input logic [7:0] o2,
		input logic [7:0] n, input logic [31:0] lw, input logic [31:0] rw);
		int w, p1, p2;
		logic rl, sl, b1, b2, lsb, d, e, ln;
		logic [31:0] fw, sw, rd, mask;
		logic [1:0] r;
		@(posedge aclk);
		aresetn <= 1'b0;
		fmt <= f;
		wlen <= wl;
		off1 <= o1;
		off2 <= o2;
		{early_hiz, hiz_en, bclk_inv, swap, tslot} <= fl;
		left_word <= lw;
		right_word <= rw;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axi_wr(REG_OFFS, {8'h00, n, o2, o1}, r);
		axi_wr(REG_CTRL, {24'h000000, fl[2:0], wl, f, 1'b1}, r);
		chk(r, RESP_OKAY);
		w = (wl == WLEN_32) ? 32 : 16 + 4 * wl;
		p1 = o1 + ((f == ASSF_FMT_I2S) ? 2 : 1);
		if (!fl[0])
			p2 = (f == ASSF_FMT_DSP) ? p1 + w : p1 + n / 2;
		else if (f != ASSF_FMT_DSP)
			p2 = p1 + w + o2;
		else
			p2 = p1 + w - 1 + ((o2 == 8'h00) ? 1 : o2);
		fw = fl[1] ? rw : lw;
		sw = fl[1] ? lw : rw;
		rl = (f != ASSF_FMT_I2S);
		sl = (f != ASSF_FMT_DSP) ^ fl[2];
		repeat (2) wait_edge(1'b1, rl);
		// The sampling pulse trails the frame edge by the launch delay,
		// which in DSP framing comes half a bit later.
		repeat (3) @(posedge aclk);
		#1;
		chk(word_taken, f != ASSF_FMT_DSP);
		repeat (4) @(posedge aclk);
		#1;
		chk(word_taken, f == ASSF_FMT_DSP);
		wait_edge(1'b1, rl);
		for (int i = 1; i <= n; i++) begin
			wait_edge(1'b0, sl);
			b1 = (i >= p1 && i < p1 + w);
			b2 = (i >= p2 && i < p2 + w);
			d = b1 ? fw[w - 1 - (i - p1)] : sw[w - 1 - (i - p2)];
			lsb = (b1 && i == p1 + w - 1) || (b2 && i == p2 + w - 1);
			if (b1 || b2)
				chk({i_assf_link_if.dout_oe, i_assf_link_if.dout},
					{1'b1, d});
			repeat (4) @(posedge aclk);
			#1;
			if (!(b1 || b2))
				e = fl[3] ? 1'bz : 1'b0;
			else
				e = (lsb && fl[3] && fl[4]) ? 1'bz : d;
			ln = i_assf_link_if.dout_oe ? i_assf_link_if.dout : 1'bz;
			chk(ln, e);
		end
		wait_edge(1'b1, rl);
		repeat (8) @(posedge aclk);
		mask = (w == 32) ? 32'hffffffff : (32'h00000001 << w) - 32'h00000001;
		axi_rd(REG_LEFT, rd, r);
		chk(rd, lw & mask);
		axi_rd(REG_RIGHT, rd, r);
		chk(rd, rw & mask);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic sc_regs();
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(REG_CTRL, d, r);
		chk(d, CTRL_RESET);
		axi_rd(REG_OFFS, d, r);
		chk(d, OFFS_RESET);
		axi_rd(8'h14, d, r);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR});
		axi_wr(REG_LEFT, 32'h12345678, r);
		chk(r, RESP_SLVERR);
	endtask

	task automatic sc_frames();
		logic [31:0] a, b;
		logic [1:0] r;
		axi_rd(REG_STAT, a, r);
		wait_edge(1'b1, 1'b1);
		repeat (8) @(posedge aclk);
		axi_rd(REG_STAT, b, r);
		chk(b[15:0], a[15:0] + 16'h0001);
	endtask

	task automatic sc_lj_plain();
		run_case(ASSF_FMT_LJ, WLEN_16, 5'h08, 8'h00, 8'h00, 8'h40,
			32'hfff0a5c3, 32'h12343c5a);
	endtask
	task automatic sc_lj_slot();
		run_case(ASSF_FMT_LJ, WLEN_24, 5'h09, 8'h00, 8'h01, 8'h40,
			32'h00c3a581, 32'hff5a3c7e);
	endtask
	task automatic sc_lj_slot_swap();
		run_case(ASSF_FMT_LJ, WLEN_16, 5'h0b, 8'h02, 8'h01, 8'h40,
			32'h0000b00d, 32'h0000600f);
	endtask
	task automatic sc_i2s();
		run_case(ASSF_FMT_I2S, WLEN_24, 5'h08, 8'h02, 8'h00, 8'h40,
			32'h00a1b2c3, 32'h00d4e5f6);
	endtask
	task automatic sc_dsp_slot();
		run_case(ASSF_FMT_DSP, WLEN_32, 5'h09, 8'h00, 8'h03, 8'h50,
			32'h80000001, 32'h7ffffffe);
	endtask
	task automatic sc_dsp_slot_swap();
		run_case(ASSF_FMT_DSP, WLEN_16, 5'h1b, 8'h00, 8'h03, 8'h40,
			32'h0000c001, 32'h00008ff1);
	endtask
	task automatic sc_lj_swap_inv();
		run_case(ASSF_FMT_LJ, WLEN_20, 5'h06, 8'h01, 8'h00, 8'h40,
			32'h000f1e2d, 32'h00087654);
	endtask
	task automatic sc_dsp_inv();
		run_case(ASSF_FMT_DSP, WLEN_16, 5'h04, 8'h01, 8'h00, 8'h40,
			32'h00009a5e, 32'h000071c3);
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			num_errors++;
			complete_run();
		end
	end

	initial begin
		num_errors = 0;
		tests_run = 0;
		cycles = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		fmt = ASSF_FMT_LJ;
		wlen = WLEN_16;
		{early_hiz, hiz_en, bclk_inv, swap, tslot} = 5'h00;
		off1 = 8'h00;
		off2 = 8'h00;
		left_word = 32'h0;
		right_word = 32'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		sc_regs();
		sc_lj_plain();
		sc_lj_slot();
		sc_lj_slot_swap();
		sc_i2s();
		sc_dsp_slot();
		sc_dsp_slot_swap();
		sc_lj_swap_inv();
		sc_dsp_inv();
		sc_frames();
		complete_run();
	end
endmodule // tb
